// ### fpe_regs.svh
// Register offsets, field positions, reset values for the four-bit port
`ifndef FPE_REGS_SVH
`define FPE_REGS_SVH

`define FPE_OFS_PIN_VALUE   12'h000
`define FPE_OFS_DIRECTION   12'h004
`define FPE_OFS_LATCH       12'h008
`define FPE_OFS_ANALOG      12'h00c
`define FPE_OFS_PULLUP      12'h010
`define FPE_OFS_CONFIG      12'h014

`define FPE_BIDIR_W         3
`define FPE_INPUT_BIT       3
`define FPE_CFG_GLOBAL_BIT  0
`define FPE_CFG_EXTRST_BIT  1

`define FPE_RST_DIRECTION   3'h7
`define FPE_RST_LATCH       3'h0
`define FPE_RST_ANALOG      3'h7
`define FPE_RST_PULLUP      1'h1
`define FPE_RST_GLOBAL_N    1'h1
`define FPE_RST_EXTRST      1'h0

`define FPE_RESP_OKAY       2'h0
`define FPE_RESP_SLVERR     2'h2

`endif

// ### fpe_pkg.sv
// Types shared by the four-bit port modules
`default_nettype none
package fpe_pkg;
    typedef enum logic [0:0] {
        FPE_IDLE = 1'b0,
        FPE_RESP = 1'b1
    } fpe_phase_t;
endpackage : fpe_pkg
`default_nettype wire

// ### fpe_cfg_if.sv
// Configuration carried from the register file to the pad logic
`default_nettype none
interface fpe_cfg_if;
    logic [2:0] direction;
    logic [2:0] latch;
    logic [2:0] analog;
    logic       pullup_en;
    logic       global_pullup_disable_n;
    logic       ext_reset_pin_select;
    logic [3:0] pin_read;
    modport regs (output direction, output latch, output analog,
                  output pullup_en, output global_pullup_disable_n,
                  output ext_reset_pin_select, input pin_read);
    modport pads (input direction, input latch, input analog,
                  input pullup_en, input global_pullup_disable_n,
                  input ext_reset_pin_select, output pin_read);
endinterface : fpe_cfg_if
`default_nettype wire

// ### fpe_pads.sv
// Pad-side logic: drivers, pull-up control and pin read masking
`default_nettype none
module fpe_pads (
    // Configuration
    fpe_cfg_if.pads          cfg,
    // Pins
    input  wire logic [2:0]  bidir_pins_i,
    output logic      [2:0]  bidir_pins_o,
    output logic      [2:0]  bidir_pins_oe,
    input  wire logic        input_only_pin,
    output logic             input_pin_pullup_on
);
    assign bidir_pins_o  = cfg.latch;
    assign bidir_pins_oe = ~cfg.direction;
    assign input_pin_pullup_on = cfg.pullup_en
                               & ~cfg.global_pullup_disable_n;
    assign cfg.pin_read = {input_only_pin & ~cfg.ext_reset_pin_select,
                           bidir_pins_i & ~cfg.analog};
endmodule : fpe_pads
`default_nettype wire

// ### fpe_port.sv
// Four-bit port: AXI4-Lite register file and pin control
`include "fpe_regs.svh"
`default_nettype none

// How it works
// - Output pins are driven only from the port's own output latch.
// - Pin-value reads return actual pin logic levels.
// - Writes to pin-value bits 2..0 update the output latch.
// - Small variant: bits 2..0 absent, read zero; only bit 3 remains.
// - Direction bit 1 tri-states the driver; 0 drives latch onto pin.
// - Direction bit 3 has no storage, reads one; bits 7..4 read zero.
// - Latch holds bits 2..0; bits 7..3 read zero.
// - Analog bit 1 makes pin analog and disables digital input.
// - Pull-up bit 3 enables input-only pin pull-up; others read zero.
// - Pull-up active only while global active-low enable is cleared.
// - Pull-up ignores the direction register; its pin is never an output.
// - Analog pins read zero through the pin-value register.
// - Input-only pin reads zero while external reset function selected.
module fpe_port #(
    parameter bit FULL_VARIANT = 1'b1
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_b,
    // AXI4-Lite write address
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Pins
    input  wire logic [2:0]  bidir_pins_i,
    output logic      [2:0]  bidir_pins_o,
    output logic      [2:0]  bidir_pins_oe,
    input  wire logic        input_only_pin,
    output logic             input_pin_pullup_on
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0]  direction;
        logic [2:0]  latch;
        logic [2:0]  analog;
        logic        pullup_en;
        logic        global_n;
        logic        extrst;
        logic        aw_held;
        logic [11:0] aw_addr;
        logic        w_held;
        logic [31:0] w_data;
        logic        w_strb0;
        fpe_pkg::fpe_phase_t wph;
        logic [1:0]  bresp;
        fpe_pkg::fpe_phase_t rph;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } fpe_state_t;

    fpe_state_t st;
    fpe_state_t next_st;

    fpe_cfg_if cfg ();

    // Variant mask for the three bidirectional bits
    localparam logic [2:0] BIDIR_MASK = FULL_VARIANT ? 3'h7 : 3'h0;

    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == `FPE_OFS_PIN_VALUE) || (a == `FPE_OFS_DIRECTION) ||
                 (a == `FPE_OFS_LATCH)     || (a == `FPE_OFS_ANALOG)    ||
                 (a == `FPE_OFS_PULLUP)    || (a == `FPE_OFS_CONFIG);
    endfunction : mapped

    function automatic logic [7:0] rd_value(input logic [11:0] a,
                                            input fpe_state_t s,
                                            input logic [3:0] pins);
        rd_value = 8'h00;
        case (a)
            `FPE_OFS_PIN_VALUE: rd_value = {4'h0, pins[3],
                                            pins[2:0] & BIDIR_MASK};
            `FPE_OFS_DIRECTION: rd_value = {4'h0, 1'b1,
                                            s.direction & BIDIR_MASK};
            `FPE_OFS_LATCH:     rd_value = {5'h00, s.latch & BIDIR_MASK};
            `FPE_OFS_ANALOG:    rd_value = {5'h00, s.analog & BIDIR_MASK};
            `FPE_OFS_PULLUP:    rd_value = {4'h0, s.pullup_en, 3'h0};
            `FPE_OFS_CONFIG:    rd_value = {6'h00, s.extrst, s.global_n};
            default:            rd_value = 8'h00;
        endcase
    endfunction : rd_value

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        if (s_axi_awvalid && s_axi_awready) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_st.w_held  = 1'b1;
            next_st.w_data  = s_axi_wdata;
            next_st.w_strb0 = s_axi_wstrb[0];
        end
        if (st.wph == fpe_pkg::FPE_IDLE && st.aw_held && st.w_held) begin
            next_st.aw_held = 1'b0;
            next_st.w_held  = 1'b0;
            next_st.wph     = fpe_pkg::FPE_RESP;
            next_st.bresp   = mapped(st.aw_addr) ? `FPE_RESP_OKAY
                                                 : `FPE_RESP_SLVERR;
            if (st.w_strb0) begin
                case (st.aw_addr)
                    // pin-value write goes to latch, bit 3 dropped
                    `FPE_OFS_PIN_VALUE: next_st.latch = st.w_data[2:0];
                    `FPE_OFS_DIRECTION: next_st.direction = st.w_data[2:0];
                    `FPE_OFS_LATCH:     next_st.latch = st.w_data[2:0];
                    `FPE_OFS_ANALOG:    next_st.analog = st.w_data[2:0];
                    `FPE_OFS_PULLUP:
                        next_st.pullup_en = st.w_data[`FPE_INPUT_BIT];
                    `FPE_OFS_CONFIG: begin
                        next_st.global_n = st.w_data[`FPE_CFG_GLOBAL_BIT];
                        next_st.extrst   = st.w_data[`FPE_CFG_EXTRST_BIT];
                    end
                    default: ;
                endcase
            end
        end
        if (st.wph == fpe_pkg::FPE_RESP && s_axi_bready) begin
            next_st.wph = fpe_pkg::FPE_IDLE;
        end
        case (st.rph)
            fpe_pkg::FPE_IDLE: begin
                if (s_axi_arvalid) begin
                    next_st.rph   = fpe_pkg::FPE_RESP;
                    next_st.rdata = {24'h000000,
                                     rd_value(s_axi_araddr, st,
                                              cfg.pin_read)};
                    next_st.rresp = mapped(s_axi_araddr) ? `FPE_RESP_OKAY
                                                         : `FPE_RESP_SLVERR;
                end
            end
            fpe_pkg::FPE_RESP: begin
                if (s_axi_rready) begin
                    next_st.rph = fpe_pkg::FPE_IDLE;
                end
            end
            default: next_st.rph = fpe_pkg::FPE_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st           <= '0;
            st.direction <= `FPE_RST_DIRECTION;
            st.latch     <= `FPE_RST_LATCH;
            st.analog    <= `FPE_RST_ANALOG;
            st.pullup_en <= `FPE_RST_PULLUP;
            st.global_n  <= `FPE_RST_GLOBAL_N;
            st.extrst    <= `FPE_RST_EXTRST;
            st.wph       <= fpe_pkg::FPE_IDLE;
            st.rph       <= fpe_pkg::FPE_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Bus outputs
    // ------------------------------------------------------------
    assign s_axi_awready = !st.aw_held;
    assign s_axi_wready  = !st.w_held;
    assign s_axi_bvalid  = (st.wph == fpe_pkg::FPE_RESP);
    assign s_axi_bresp   = st.bresp;
    assign s_axi_arready = (st.rph == fpe_pkg::FPE_IDLE);
    assign s_axi_rvalid  = (st.rph == fpe_pkg::FPE_RESP);
    assign s_axi_rdata   = st.rdata;
    assign s_axi_rresp   = st.rresp;

    // ------------------------------------------------------------
    // Pad side
    // ------------------------------------------------------------
    // small variant disables bidir drivers
    assign cfg.direction = st.direction | ~BIDIR_MASK;
    assign cfg.latch     = st.latch & BIDIR_MASK;
    assign cfg.analog    = st.analog | ~BIDIR_MASK;
    assign cfg.pullup_en = st.pullup_en;
    assign cfg.global_pullup_disable_n = st.global_n;
    assign cfg.ext_reset_pin_select    = st.extrst;

    fpe_pads u_pads (
        .cfg                 (cfg.pads),
        .bidir_pins_i        (bidir_pins_i),
        .bidir_pins_o        (bidir_pins_o),
        .bidir_pins_oe       (bidir_pins_oe),
        .input_only_pin      (input_only_pin),
        .input_pin_pullup_on (input_pin_pullup_on)
    );

endmodule : fpe_port
`default_nettype wire

// ### fpe_pin_model.sv
// Outside circuitry seen by the four port pins
`default_nettype none
module fpe_pin_model (
    // Clock
    input  wire logic       mclk,
    // Port side
    input  wire logic [2:0] bidir_pins_o,
    input  wire logic [2:0] bidir_pins_oe,
    input  wire logic       input_pin_pullup_on,
    output logic      [2:0] bidir_pins_i,
    output logic            input_only_pin,
    // Outside drivers set by the bench
    input  wire logic [2:0] ext_lvl,
    input  wire logic [2:0] ext_drv,
    input  wire logic       ext_in_lvl,
    input  wire logic       ext_in_drv
);
    timeunit 1ns;
    timeprecision 1ps;
    logic flip = 1'b0;
    // Floating lines wander so a stale level never reads as valid
    always @(posedge mclk) flip <= ~flip;
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            bidir_pins_i[i] = bidir_pins_oe[i] ? bidir_pins_o[i]
                            : (ext_drv[i] ? ext_lvl[i] : flip);
        end
        input_only_pin = ext_in_drv ? ext_in_lvl
                       : (input_pin_pullup_on ? 1'b1 : flip);
    end
endmodule : fpe_pin_model
`default_nettype wire

// ### fpe_port_chk.sv
// Port-level assertions for the four-bit port
`include "fpe_regs.svh"
`default_nettype none
module fpe_port_chk (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        rst_b,
    // Bus
    input wire logic [11:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_bvalid,
    // Pins
    input wire logic [2:0]  bidir_pins_o,
    input wire logic [2:0]  bidir_pins_oe,
    input wire logic        input_pin_pullup_on
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    logic [11:0] rd_addr;
    // Address of the read now answered
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) rd_addr <= 12'h000;
        else if (s_axi_arvalid && s_axi_arready) rd_addr <= s_axi_araddr;
    end
    pins_by_write_a: assert property (
        $changed(bidir_pins_o) |-> $rose(s_axi_bvalid))
        else $error("pin level moved without a write");
    drive_by_write_a: assert property (
        $changed(bidir_pins_oe) |-> $rose(s_axi_bvalid))
        else $error("drive enable moved without a write");
    pullup_by_write_a: assert property (
        $changed(input_pin_pullup_on) |-> $rose(s_axi_bvalid))
        else $error("pull-up moved without a write");
    read_answer_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    dir_read_a: assert property (
        s_axi_rvalid && rd_addr == `FPE_OFS_DIRECTION
        |-> s_axi_rdata[31:3] == 29'h1) else $error("direction upper bits");
    latch_read_a: assert property (
        s_axi_rvalid && rd_addr == `FPE_OFS_LATCH
        |-> s_axi_rdata[31:3] == 29'h0) else $error("latch upper bits");
    pullup_read_a: assert property (
        s_axi_rvalid && rd_addr == `FPE_OFS_PULLUP
        |-> s_axi_rdata[31:4] == 28'h0 && s_axi_rdata[2:0] == 3'h0)
        else $error("pull-up unused bits");
    pin_read_a: assert property (
        s_axi_rvalid && rd_addr == `FPE_OFS_PIN_VALUE
        |-> s_axi_rdata[31:4] == 28'h0) else $error("pin value upper bits");
    cover property ($rose(s_axi_bvalid));
    cover property (s_axi_rvalid && rd_addr == `FPE_OFS_DIRECTION);
    cover property ($rose(input_pin_pullup_on));
endmodule : fpe_port_chk
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the four-bit port
`include "fpe_regs.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] PV = `FPE_OFS_PIN_VALUE, DR = `FPE_OFS_DIRECTION,
        LT = `FPE_OFS_LATCH, AN = `FPE_OFS_ANALOG, PU = `FPE_OFS_PULLUP,
        CF = `FPE_OFS_CONFIG;
    logic mclk = 1'b0, rst_b = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, input_only_pin, input_pin_pullup_on;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [2:0] bidir_pins_i, bidir_pins_o, bidir_pins_oe;
    logic [2:0] oe_small;
    logic [31:0] rdata_small;
    logic [2:0] ext_lvl = 3'h0, ext_drv = 3'h0;
    logic ext_in_lvl = 1'b1, ext_in_drv = 1'b1;
    int miscompares = 0, compares = 0, cycles = 0;
    always #5 mclk = ~mclk;
    fpe_port #(.FULL_VARIANT(1'b1)) dut (.mclk, .rst_b, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .bidir_pins_i, .bidir_pins_o, .bidir_pins_oe, .input_only_pin,
        .input_pin_pullup_on);
    fpe_pin_model pins (.mclk, .bidir_pins_o, .bidir_pins_oe,
        .input_pin_pullup_on, .bidir_pins_i, .input_only_pin, .ext_lvl,
        .ext_drv, .ext_in_lvl, .ext_in_drv);
    // Small package variant sees the same bus traffic and pin levels
    fpe_port #(.FULL_VARIANT(1'b0)) dut_small (.mclk, .rst_b,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready(), .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready(), .s_axi_bresp(),
        .s_axi_bvalid(), .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready(), .s_axi_rdata(rdata_small), .s_axi_rresp(),
        .s_axi_rvalid(), .s_axi_rready, .bidir_pins_i,
        .bidir_pins_o(), .bidir_pins_oe(oe_small), .input_only_pin,
        .input_pin_pullup_on());
    task automatic chk(input string n, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        bit ta = 1'b0, tw = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(ta && tw)) begin
            @(posedge mclk);
            if (s_axi_awvalid && s_axi_awready) begin
                ta = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                tw = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge mclk); while (!s_axi_bvalid);
        chk("bresp", 32'h0, {30'h0, s_axi_bresp});
    endtask : wr
    task automatic rd(input string n, input logic [11:0] a,
                      input logic [7:0] e, input logic [1:0] er = 2'h0);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge mclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge mclk); while (!s_axi_rvalid);
        chk(n, {24'h0, e}, s_axi_rdata);
        chk({n, "_small"}, {24'h0, (a == PU || a == CF) ? e : (e & 8'h08)},
            rdata_small);
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask : rd
    task automatic t_reset;
        rd("pin", PV, 8'h08);
        rd("dir", DR, 8'h0f);
        rd("lat", LT, 8'h00);
        rd("ana", AN, 8'h07);
        rd("pu", PU, 8'h08);
        rd("cfg", CF, 8'h01);
        rd("hole", 12'h018, 8'h00, `FPE_RESP_SLVERR);
        chk("pu_on", 32'h0, {31'h0, input_pin_pullup_on});
        $display("test reset done");
    endtask : t_reset
    task automatic t_output;
        wr(AN, 8'h00);
        wr(DR, 8'h00);
        wr(PV, 8'hfd);
        chk("oe", 32'h7, {29'h0, bidir_pins_oe});
        chk("out", 32'h5, {29'h0, bidir_pins_o});
        chk("oe_small", 32'h0, {29'h0, oe_small});
        rd("lat", LT, 8'h05);
        ext_in_lvl <= 1'b0;
        rd("pin", PV, 8'h05);
        wr(DR, 8'hfa);
        chk("oe", 32'h5, {29'h0, bidir_pins_oe});
        rd("dir", DR, 8'h0a);
        $display("test output done");
    endtask : t_output
    task automatic t_analog;
        wr(DR, 8'h07);
        ext_drv <= 3'h7;
        ext_lvl <= 3'h6;
        wr(AN, 8'h02);
        chk("oe", 32'h0, {29'h0, bidir_pins_oe});
        rd("pin", PV, 8'h04);
        wr(AN, 8'h00);
        rd("pin", PV, 8'h06);
        $display("test analog done");
    endtask : t_analog
    task automatic t_pullup;
        ext_in_drv <= 1'b0;
        wr(CF, 8'h00);
        chk("pu_on", 32'h1, {31'h0, input_pin_pullup_on});
        rd("pin", PV, 8'h0e);
        wr(PU, 8'hf7);
        chk("pu_on", 32'h0, {31'h0, input_pin_pullup_on});
        rd("pu", PU, 8'h00);
        wr(PU, 8'hff);
        rd("pu", PU, 8'h08);
        wr(DR, 8'h00);
        chk("pu_on", 32'h1, {31'h0, input_pin_pullup_on});
        wr(CF, 8'h01);
        chk("pu_on", 32'h0, {31'h0, input_pin_pullup_on});
        $display("test pullup done");
    endtask : t_pullup
    task automatic t_extrst;
        ext_in_drv <= 1'b1;
        ext_in_lvl <= 1'b1;
        wr(DR, 8'h07);
        wr(CF, 8'h03);
        rd("pin", PV, 8'h06);
        wr(CF, 8'h01);
        rd("pin", PV, 8'h0e);
        $display("test extrst done");
    endtask : t_extrst
    task automatic end_sim;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_sim
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            end_sim();
        end
    end
    initial begin
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        t_reset();
        t_output();
        t_analog();
        t_pullup();
        t_extrst();
        end_sim();
    end
endmodule : tb_top
bind fpe_port fpe_port_chk chk_i (.mclk, .rst_b, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_bvalid, .bidir_pins_o, .bidir_pins_oe, .input_pin_pullup_on);
`default_nettype wire
